// File: logic/dual_timer_pkg.sv
// Package with register map, field positions and reset values of the dual timer.
package dual_timer_pkg;

  localparam logic [11:0] ADDR_MODE     = 12'h000;
  localparam logic [11:0] ADDR_CONTROL  = 12'h004;
  localparam logic [11:0] ADDR_CLOCKSEL = 12'h008;
  localparam logic [11:0] ADDR_CNT0     = 12'h00C;
  localparam logic [11:0] ADDR_CNT1     = 12'h010;
  localparam logic [11:0] ADDR_IRQ_STAT = 12'h014;
  localparam logic [11:0] ADDR_IRQ_MASK = 12'h018;
  localparam logic [11:0] ADDR_IRQ_ACK  = 12'h01C;

  // Timer mode register: per counter a nibble {gate, function, mode_high, mode_low}.
  localparam int MODE_FUNC_BIT0 = 2;
  localparam int MODE_FUNC_BIT1 = 6;
  localparam int MODE_GATE_BIT0 = 3;
  localparam int MODE_GATE_BIT1 = 7;
  localparam int MODE_SEL_LSB0  = 0;
  localparam int MODE_SEL_LSB1  = 4;

  // Timer control register: run bits at 4 and 6, overflow flags at 5 and 7.
  localparam int CTRL_RUN0_BIT  = 4;
  localparam int CTRL_FLAG0_BIT = 5;
  localparam int CTRL_RUN1_BIT  = 6;
  localparam int CTRL_FLAG1_BIT = 7;

  // Clock control register: time-base select bits.
  localparam int CLKSEL_CNT0_BIT = 0;
  localparam int CLKSEL_CNT1_BIT = 1;

  localparam logic [7:0]  MODE_RESET     = 8'h00;
  localparam logic [7:0]  CONTROL_RESET  = 8'h00;
  localparam logic [1:0]  CLKSEL_RESET   = 2'h0;
  localparam logic [15:0] COUNT_RESET    = 16'h0000;

  // Machine cycle: twelve clocks in standard rate, four in fast rate.
  localparam logic [3:0] SLOW_CYCLE_LAST = 4'hB;
  localparam logic [3:0] FAST_CYCLE_LAST = 4'h3;
  // Phase at which pins are sampled (C4) and counts update (C3), as clock index.
  localparam logic [3:0] PHASE_SAMPLE    = 4'h3;
  localparam logic [3:0] PHASE_UPDATE    = 4'h2;

  localparam logic [1:0] TMODE_13BIT  = 2'h0;
  localparam logic [1:0] TMODE_16BIT  = 2'h1;
  localparam logic [1:0] TMODE_RELOAD = 2'h2;
  localparam logic [1:0] TMODE_FREEZE = 2'h3;

  typedef struct packed {
    logic       gate;
    logic       func;
    logic [1:0] mode;
  } cnt_cfg_t;

  typedef struct packed {
    logic [15:0] value;
    logic        wrap;
  } cnt_step_t;

endpackage : dual_timer_pkg

// File: logic/dual_timer_counter.sv
// Two 16-bit timer/counters with modes 0 to 3 (mode 3 holds the count), AHB-Lite registers and interrupt.
module dual_timer_counter (
  input  wire logic        i_clock,
  input  wire logic        i_reset,
  input  wire logic        i_hsel,
  input  wire logic [31:0] i_haddr,
  input  wire logic [1:0]  i_htrans,
  input  wire logic        i_hwrite,
  input  wire logic [2:0]  i_hsize,
  input  wire logic [31:0] i_hwdata,
  input  wire logic        i_hready,
  output logic      [31:0] o_hrdata,
  output logic             o_hreadyout,
  output logic             o_hresp,
  input  wire logic        i_count_pin_zero,
  input  wire logic        i_count_pin_one,
  input  wire logic [1:0]  i_external_irq_pin,
  input  wire logic [1:0]  i_service_entry,
  output logic      [1:0]  o_overflow_flag,
  output logic             o_irq
);

  logic [7:0]  timer_mode_register_q;
  logic [7:0]  timer_control_register_q;
  logic [1:0]  clock_control_register_q;
  logic [7:0]  cnt_high_q [2];
  logic [7:0]  cnt_low_q  [2];
  logic [1:0]  irq_mask_q;
  logic [2:0]  pin0_sync_q;
  logic [2:0]  pin1_sync_q;
  logic [2:0]  gate0_sync_q;
  logic [2:0]  gate1_sync_q;
  logic [1:0]  pin_level_q;
  logic [1:0]  gate_level_q;
  logic [1:0]  pin_sample_q;
  logic [1:0]  edge_pending_q;
  logic [3:0]  phase_q    [2];
  logic        wr_pend_q;
  logic [11:0] wr_addr_q;
  logic [31:0] rdata_d;
  logic [1:0]  flag_set;
  logic [1:0]  tick;
  logic [1:0]  update_now;
  logic [1:0]  sample_now;
  logic        bus_take;
  logic [1:0]  run_bit;
  logic [1:0]  src_sel;
  dual_timer_pkg::cnt_cfg_t  cfg  [2];
  dual_timer_pkg::cnt_step_t step [2];

  function automatic dual_timer_pkg::cnt_cfg_t cfg_of(input logic [7:0] mode_reg,
                                                      input int idx);
    dual_timer_pkg::cnt_cfg_t c;
    c = (idx == 0) ? dual_timer_pkg::cnt_cfg_t'(mode_reg[3:0])
                   : dual_timer_pkg::cnt_cfg_t'(mode_reg[7:4]);
    return c;
  endfunction : cfg_of

  // One increment of a counter in the given mode, reporting overflow.
  function automatic dual_timer_pkg::cnt_step_t count_step(input logic [1:0] mode,
                                                           input logic [7:0] hi,
                                                           input logic [7:0] lo);
    dual_timer_pkg::cnt_step_t s;
    logic [8:0] lo_next;
    logic [8:0] hi_next;
    lo_next = {1'b0, lo} + 9'h001;
    hi_next = {1'b0, hi} + 9'h001;
    s.value = {hi, lo};
    s.wrap  = 1'b0;
    case (mode)
      dual_timer_pkg::TMODE_13BIT: begin
        // Upper three low bits are left as they stand.
        if (lo[4:0] == 5'h1F) begin
          s.value = {hi_next[7:0], lo[7:5], 5'h00};
          s.wrap  = hi_next[8];
        end else begin
          s.value = {hi, lo[7:5], lo_next[4:0]};
        end
      end
      dual_timer_pkg::TMODE_16BIT: begin
        s.value = {hi, lo} + 16'h0001;
        s.wrap  = ({hi, lo} == 16'hFFFF);
      end
      dual_timer_pkg::TMODE_RELOAD: begin
        s.value = lo_next[8] ? {hi, hi} : {hi, lo_next[7:0]};
        s.wrap  = lo_next[8];
      end
      default: begin
        s.value = {hi, lo};
        s.wrap  = 1'b0;
      end
    endcase
    return s;
  endfunction : count_step

  // True when the pending data phase writes the given register.
  function automatic logic write_hit(input logic        pend,
                                     input logic [11:0] addr,
                                     input logic [11:0] target);
    return pend && (addr == target);
  endfunction : write_hit

  // Both overflow flags as one vector, counter 1 in the upper bit.
  function automatic logic [1:0] flags_of(input logic [7:0] ctl);
    return {ctl[dual_timer_pkg::CTRL_FLAG1_BIT], ctl[dual_timer_pkg::CTRL_FLAG0_BIT]};
  endfunction : flags_of

  // Run bit of one counter, taken from the control register.
  function automatic logic run_of(input logic [7:0] ctl,
                                  input int         idx);
    return (idx == 0) ? ctl[dual_timer_pkg::CTRL_RUN0_BIT]
                      : ctl[dual_timer_pkg::CTRL_RUN1_BIT];
  endfunction : run_of

  // Pins: three flops, a change counts once the last two agree.
  always_ff @(posedge i_clock or posedge i_reset) begin
    if (i_reset) begin
      pin0_sync_q  <= 3'h0;
      pin1_sync_q  <= 3'h0;
      gate0_sync_q <= 3'h0;
      gate1_sync_q <= 3'h0;
      pin_level_q  <= 2'h0;
      gate_level_q <= 2'h0;
    end else begin
      pin0_sync_q  <= {pin0_sync_q[1:0], i_count_pin_zero};
      pin1_sync_q  <= {pin1_sync_q[1:0], i_count_pin_one};
      gate0_sync_q <= {gate0_sync_q[1:0], i_external_irq_pin[0]};
      gate1_sync_q <= {gate1_sync_q[1:0], i_external_irq_pin[1]};
      if (pin0_sync_q[2] == pin0_sync_q[1]) begin
        pin_level_q[0] <= pin0_sync_q[2];
      end
      if (pin1_sync_q[2] == pin1_sync_q[1]) begin
        pin_level_q[1] <= pin1_sync_q[2];
      end
      if (gate0_sync_q[2] == gate0_sync_q[1]) begin
        gate_level_q[0] <= gate0_sync_q[2];
      end
      if (gate1_sync_q[2] == gate1_sync_q[1]) begin
        gate_level_q[1] <= gate1_sync_q[2];
      end
    end
  end

  // Machine-cycle phase per counter; the rate follows its time-base bit.
  // Each counter keeps its own phase, so changing one time base leaves the other alone.
  // A phase beyond the new last value after a switch to the fast rate restarts at once.
  always_ff @(posedge i_clock or posedge i_reset) begin
    if (i_reset) begin
      phase_q[0] <= 4'h0;
      phase_q[1] <= 4'h0;
    end else begin
      for (int i = 0; i < 2; i++) begin
        if (phase_q[i] >= (clock_control_register_q[i] ? dual_timer_pkg::FAST_CYCLE_LAST
                                                       : dual_timer_pkg::SLOW_CYCLE_LAST)) begin
          phase_q[i] <= 4'h0;
        end else begin
          phase_q[i] <= phase_q[i] + 4'h1;
        end
      end
    end
  end

  always_comb begin
    for (int i = 0; i < 2; i++) begin
      sample_now[i] = (phase_q[i] == dual_timer_pkg::PHASE_SAMPLE);
      update_now[i] = (phase_q[i] == dual_timer_pkg::PHASE_UPDATE);
    end
  end

  // Edge detection at C4; the edge is held and spent at the next C3.
  // The sample starts low after reset, so a pin that idles high gives no false edge.
  // Only one edge can wait per machine cycle, which is why the source must stay slow.
  always_ff @(posedge i_clock or posedge i_reset) begin
    if (i_reset) begin
      pin_sample_q   <= 2'h0;
      edge_pending_q <= 2'h0;
    end else begin
      for (int i = 0; i < 2; i++) begin
        if (sample_now[i]) begin
          pin_sample_q[i] <= pin_level_q[i];
          if (pin_sample_q[i] && !pin_level_q[i]) begin
            edge_pending_q[i] <= 1'b1;
          end
        end else if (update_now[i]) begin
          edge_pending_q[i] <= 1'b0;
        end
      end
    end
  end

  // The gate pin is read through its filter, so a glitch shorter than two clocks is lost.
  always_comb begin
    for (int i = 0; i < 2; i++) begin
      cfg[i]      = cfg_of(timer_mode_register_q, i);
      run_bit[i]  = run_of(timer_control_register_q, i);
      src_sel[i]  = cfg[i].func ? edge_pending_q[i] : 1'b1;
      tick[i]     = update_now[i] && src_sel[i] && run_bit[i]
                    && (!cfg[i].gate || gate_level_q[i]);
      step[i]     = count_step(cfg[i].mode, cnt_high_q[i], cnt_low_q[i]);
      flag_set[i] = tick[i] && step[i].wrap;
    end
  end

  // Only the low twelve address bits decode, so the map repeats across the window.
  assign bus_take = i_hsel && i_hready && i_htrans[1];

  // Write address phase is held so the data phase can apply it.
  always_ff @(posedge i_clock or posedge i_reset) begin
    if (i_reset) begin
      wr_pend_q <= 1'b0;
      wr_addr_q <= 12'h000;
    end else if (i_hready) begin
      wr_pend_q <= bus_take && i_hwrite;
      wr_addr_q <= i_haddr[11:0];
    end
  end

  always_ff @(posedge i_clock or posedge i_reset) begin
    if (i_reset) begin
      timer_mode_register_q    <= dual_timer_pkg::MODE_RESET;
      clock_control_register_q <= dual_timer_pkg::CLKSEL_RESET;
      irq_mask_q               <= 2'h0;
    end else if (wr_pend_q) begin
      case (wr_addr_q)
        dual_timer_pkg::ADDR_MODE:     timer_mode_register_q    <= i_hwdata[7:0];
        dual_timer_pkg::ADDR_CLOCKSEL: clock_control_register_q <= i_hwdata[1:0];
        dual_timer_pkg::ADDR_IRQ_MASK: irq_mask_q               <= i_hwdata[1:0];
        default: begin
        end
      endcase
    end
  end

  // Flags: a hardware overflow wins over a same-cycle clear.
  always_ff @(posedge i_clock or posedge i_reset) begin
    if (i_reset) begin
      timer_control_register_q <= dual_timer_pkg::CONTROL_RESET;
    end else begin
      logic [7:0] ctl;
      ctl = timer_control_register_q;
      if (write_hit(wr_pend_q, wr_addr_q, dual_timer_pkg::ADDR_CONTROL)) begin
        ctl = i_hwdata[7:0];
      end
      if (write_hit(wr_pend_q, wr_addr_q, dual_timer_pkg::ADDR_IRQ_STAT)) begin
        if (i_hwdata[0]) ctl[dual_timer_pkg::CTRL_FLAG0_BIT] = 1'b0;
        if (i_hwdata[1]) ctl[dual_timer_pkg::CTRL_FLAG1_BIT] = 1'b0;
      end
      if (i_service_entry[0]) ctl[dual_timer_pkg::CTRL_FLAG0_BIT] = 1'b0;
      if (i_service_entry[1]) ctl[dual_timer_pkg::CTRL_FLAG1_BIT] = 1'b0;
      if (flag_set[0]) ctl[dual_timer_pkg::CTRL_FLAG0_BIT] = 1'b1;
      if (flag_set[1]) ctl[dual_timer_pkg::CTRL_FLAG1_BIT] = 1'b1;
      timer_control_register_q <= ctl;
    end
  end

  // Counts: a software write loses to nothing; a same-cycle tick is dropped.
  always_ff @(posedge i_clock or posedge i_reset) begin
    if (i_reset) begin
      for (int i = 0; i < 2; i++) begin
        cnt_high_q[i] <= dual_timer_pkg::COUNT_RESET[15:8];
        cnt_low_q[i]  <= dual_timer_pkg::COUNT_RESET[7:0];
      end
    end else begin
      for (int i = 0; i < 2; i++) begin
        if (write_hit(wr_pend_q, wr_addr_q, (i == 0) ? dual_timer_pkg::ADDR_CNT0
                                                     : dual_timer_pkg::ADDR_CNT1)) begin
          cnt_high_q[i] <= i_hwdata[15:8];
          cnt_low_q[i]  <= i_hwdata[7:0];
        end else if (tick[i]) begin
          cnt_high_q[i] <= step[i].value[15:8];
          cnt_low_q[i]  <= step[i].value[7:0];
        end
      end
    end
  end

  always_comb begin
    rdata_d = 32'h0000_0000;
    case (i_haddr[11:0])
      dual_timer_pkg::ADDR_MODE:     rdata_d[7:0]  = timer_mode_register_q;
      dual_timer_pkg::ADDR_CONTROL:  rdata_d[7:0]  = timer_control_register_q;
      dual_timer_pkg::ADDR_CLOCKSEL: rdata_d[1:0]  = clock_control_register_q;
      dual_timer_pkg::ADDR_CNT0:     rdata_d[15:0] = {cnt_high_q[0], cnt_low_q[0]};
      dual_timer_pkg::ADDR_CNT1:     rdata_d[15:0] = {cnt_high_q[1], cnt_low_q[1]};
      dual_timer_pkg::ADDR_IRQ_STAT: rdata_d[1:0]  = o_overflow_flag;
      dual_timer_pkg::ADDR_IRQ_MASK: rdata_d[1:0]  = irq_mask_q;
      default:                       rdata_d       = 32'h0000_0000;
    endcase
  end

  // Read data is registered at the address phase, so no wait state is needed.
  always_ff @(posedge i_clock or posedge i_reset) begin
    if (i_reset) begin
      o_hrdata    <= 32'h0000_0000;
      o_hreadyout <= 1'b1;
      o_hresp     <= 1'b0;
    end else begin
      o_hreadyout <= 1'b1;
      o_hresp     <= 1'b0;
      if (bus_take && !i_hwrite) begin
        o_hrdata <= rdata_d;
      end
    end
  end

  // Flags and interrupt leave through flip-flops, one cycle behind the control register.
  // The extra cycle keeps the outputs glitch free at the cost of one clock of latency.
  always_ff @(posedge i_clock or posedge i_reset) begin
    if (i_reset) begin
      o_overflow_flag <= 2'h0;
      o_irq           <= 1'b0;
    end else begin
      o_overflow_flag <= flags_of(timer_control_register_q);
      o_irq           <= |(flags_of(timer_control_register_q) & irq_mask_q);
    end
  end

endmodule : dual_timer_counter

// File: tb/dual_timer_checker.sv
// Checker of flag, interrupt and bus answer timing at the dual timer ports.
module dual_timer_checker (
  input wire logic        i_clock,
  input wire logic        i_reset,
  input wire logic        i_hsel,
  input wire logic [31:0] i_haddr,
  input wire logic [1:0]  i_htrans,
  input wire logic        i_hwrite,
  input wire logic [31:0] i_hwdata,
  input wire logic        i_hready,
  input wire logic [31:0] o_hrdata,
  input wire logic        o_hreadyout,
  input wire logic        o_hresp,
  input wire logic [1:0]  i_service_entry,
  input wire logic [1:0]  o_overflow_flag,
  input wire logic        o_irq
);
  timeunit 1ns;
  timeprecision 100ps;
  default clocking cb @(posedge i_clock);
  endclocking
  default disable iff (i_reset);
  wire logic take    = i_hsel & i_hready & i_htrans[1];
  wire logic wr_take = take & i_hwrite;
  a_bus_okay: assert property (o_hreadyout && !o_hresp)
    else $error("bus answer not ready or not okay");
  a_unmapped_zero: assert property (take && !i_hwrite &&
    i_haddr[11:0] == dual_timer_pkg::ADDR_IRQ_ACK |=> o_hrdata == 32'h0)
    else $error("reserved read not zero");
  a_irq_needs_flag: assert property (o_irq |-> o_overflow_flag != 2'h0)
    else $error("interrupt without flag");
  a_service_clear0: assert property (i_service_entry[0] |-> ##2 !o_overflow_flag[0])
    else $error("service entry left flag0 set");
  a_service_clear1: assert property (i_service_entry[1] |-> ##2 !o_overflow_flag[1])
    else $error("service entry left flag1 set");
  a_flag_sticky0: assert property ($fell(o_overflow_flag[0]) |->
    $past(i_service_entry[0], 2) || $past(wr_take, 3))
    else $error("flag0 dropped without cause");
  a_flag_sticky1: assert property ($fell(o_overflow_flag[1]) |->
    $past(i_service_entry[1], 2) || $past(wr_take, 3))
    else $error("flag1 dropped without cause");
  a_soft_set0: assert property (wr_take && i_haddr[11:0] == dual_timer_pkg::ADDR_CONTROL
    ##1 i_hwdata[5] |-> ##2 o_overflow_flag[0])
    else $error("software set of flag0 lost");
endmodule : dual_timer_checker

bind dual_timer_counter dual_timer_checker u_checker (
  .i_clock(i_clock), .i_reset(i_reset), .i_hsel(i_hsel), .i_haddr(i_haddr),
  .i_htrans(i_htrans), .i_hwrite(i_hwrite), .i_hwdata(i_hwdata), .i_hready(i_hready),
  .o_hrdata(o_hrdata), .o_hreadyout(o_hreadyout), .o_hresp(o_hresp),
  .i_service_entry(i_service_entry), .o_overflow_flag(o_overflow_flag), .o_irq(o_irq)
);

// File: tb/count_pin_source.sv
// External count pin source that sends a burst of falling edges.
module count_pin_source (
  input  wire logic       i_clock,
  input  wire logic       i_start,
  input  wire logic [7:0] i_pulses,
  output logic            o_pin,
  output logic            o_busy
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [7:0] left_q;
  logic [4:0] phase_q;
  initial begin
    o_pin = 1'b1;
    left_q = 8'h00;
    phase_q = 5'h00;
  end
  // Sixteen low and sixteen high clocks keep well below the fastest legal toggle rate.
  always @(posedge i_clock) begin
    if (i_start) begin
      left_q <= i_pulses;
      phase_q <= 5'h00;
    end else if (left_q != 8'h00) begin
      phase_q <= phase_q + 5'h01;
      if (phase_q == 5'h0F) o_pin <= 1'b0;
      if (phase_q == 5'h1F) begin
        o_pin <= 1'b1;
        left_q <= left_q - 8'h01;
      end
    end
  end
  assign o_busy = left_q != 8'h00;
endmodule : count_pin_source

// File: tb/dual_timer_counter_tb_top.sv
// Self-checking testbench of the dual timer/counter.
module dual_timer_counter_tb_top;
  timeunit 1ns;
  timeprecision 100ps;
  logic        i_clock, i_reset, hsel, hwrite, irq, hreadyout, hresp;
  logic        pin0, pin1, start0, start1, busy0, busy1;
  logic [31:0] haddr, hwdata, hrdata, v;
  logic [1:0]  htrans, irq_pin, svc, flags;
  logic [2:0]  hsize;
  logic [7:0]  pulses0, pulses1;
  int          err_count, samples_checked;

  dual_timer_counter u_dut (.i_clock(i_clock), .i_reset(i_reset), .i_hsel(hsel),
    .i_haddr(haddr), .i_htrans(htrans), .i_hwrite(hwrite), .i_hsize(hsize),
    .i_hwdata(hwdata), .i_hready(hreadyout), .o_hrdata(hrdata), .o_hreadyout(hreadyout),
    .o_hresp(hresp), .i_count_pin_zero(pin0), .i_count_pin_one(pin1),
    .i_external_irq_pin(irq_pin), .i_service_entry(svc), .o_overflow_flag(flags), .o_irq(irq));
  count_pin_source u_src0 (.i_clock(i_clock), .i_start(start0), .i_pulses(pulses0),
    .o_pin(pin0), .o_busy(busy0));
  count_pin_source u_src1 (.i_clock(i_clock), .i_start(start1), .i_pulses(pulses1),
    .o_pin(pin1), .o_busy(busy1));

  initial begin
    i_clock = 1'b0;
    forever #12.5 i_clock = ~i_clock;
  end

  task automatic tick(input int n);
    repeat (n) @(posedge i_clock);
    #1;
  endtask : tick
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    samples_checked++;
    if (got !== exp) begin
      err_count++;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask : chk
  task automatic chk_in(input string what, input int lo, input int hi, input logic [31:0] got);
    samples_checked++;
    if ((got >= lo && got <= hi) !== 1'b1) begin
      err_count++;
      $display("Error %s expected %0d to %0d seen %h", what, lo, hi, got);
    end
  endtask : chk_in
  // Zero-wait slave, yet the master still waits on ready as the bus demands.
  task automatic bus(input logic w, input logic [11:0] a, input logic [31:0] d);
    hsel <= 1'b1;
    haddr <= {20'h00000, a};
    htrans <= 2'h2;
    hwrite <= w;
    @(posedge i_clock);
    while (hreadyout !== 1'b1) @(posedge i_clock);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    @(posedge i_clock);
    while (hreadyout !== 1'b1) @(posedge i_clock);
    v = hrdata;
    #1;
  endtask : bus
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    bus(1'b1, a, d);
  endtask : wr
  task automatic rdchk(input string what, input logic [11:0] a, input logic [31:0] e);
    bus(1'b0, a, 32'h0);
    chk(what, e, v);
  endtask : rdchk
  task automatic run_read(input logic [7:0] ctl, input int n, input logic [11:0] a);
    wr(dual_timer_pkg::ADDR_CONTROL, {24'h0, ctl});
    tick(n);
    wr(dual_timer_pkg::ADDR_CONTROL, 32'h0);
    bus(1'b0, a, 32'h0);
  endtask : run_read

  task automatic t_reset;
    logic [11:0] a[6] = '{dual_timer_pkg::ADDR_MODE, dual_timer_pkg::ADDR_CONTROL,
      dual_timer_pkg::ADDR_CLOCKSEL, dual_timer_pkg::ADDR_CNT0, dual_timer_pkg::ADDR_CNT1,
      dual_timer_pkg::ADDR_IRQ_STAT};
    foreach (a[i]) rdchk("reset value", a[i], 32'h0);
    chk("reset flags", 32'h0, {29'h0, irq, flags});
  endtask : t_reset
  task automatic t_rate;
    for (int s = 0; s < 2; s++) begin
      wr(dual_timer_pkg::ADDR_CLOCKSEL, s ? 32'h3 : 32'h0);
      wr(dual_timer_pkg::ADDR_MODE, 32'h11);
      wr(dual_timer_pkg::ADDR_CNT0, 32'h0);
      wr(dual_timer_pkg::ADDR_CNT1, 32'h0);
      run_read(8'h50, 240, dual_timer_pkg::ADDR_CNT0);
      chk_in("count0 rate", s ? 58 : 18, s ? 62 : 22, v);
      bus(1'b0, dual_timer_pkg::ADDR_CNT1, 32'h0);
      chk_in("count1 rate", s ? 58 : 18, s ? 62 : 22, v);
    end
    wr(dual_timer_pkg::ADDR_CLOCKSEL, 32'h0);
  endtask : t_rate
  task automatic t_modes;
    logic [15:0] s[3] = '{16'hFFFE, 16'hFFFD, 16'h80FE};
    logic [15:0] e[3] = '{16'h00E0, 16'h0000, 16'h8080};
    foreach (s[i]) begin
      wr(dual_timer_pkg::ADDR_MODE, i);
      wr(dual_timer_pkg::ADDR_CNT0, {16'h0, s[i]});
      // Only the reload mode wraps again soon enough for a second pass.
      for (int r = 0; r <= i / 2; r++) begin
        wr(dual_timer_pkg::ADDR_CONTROL, 32'h10);
        for (int k = 0; k < 2000 && flags[0] !== 1'b1; k++) tick(1);
        chk("overflow flag0", 32'h1, {31'h0, flags[0]});
        wr(dual_timer_pkg::ADDR_CONTROL, 32'h0);
        rdchk("count after wrap", dual_timer_pkg::ADDR_CNT0, e[i]);
      end
    end
  endtask : t_modes
  task automatic t_gate;
    irq_pin <= 2'h0;
    wr(dual_timer_pkg::ADDR_MODE, 32'h09);
    wr(dual_timer_pkg::ADDR_CNT0, 32'h0);
    run_read(8'h10, 240, dual_timer_pkg::ADDR_CNT0);
    chk("gated count", 32'h0, v);
    irq_pin <= 2'h1;
    run_read(8'h00, 240, dual_timer_pkg::ADDR_CNT0);
    chk("stopped count", 32'h0, v);
    run_read(8'h10, 240, dual_timer_pkg::ADDR_CNT0);
    chk_in("open count", 18, 22, v);
  endtask : t_gate
  task automatic t_pins;
    wr(dual_timer_pkg::ADDR_MODE, 32'h55);
    wr(dual_timer_pkg::ADDR_CNT0, 32'h0);
    wr(dual_timer_pkg::ADDR_CNT1, 32'h0);
    wr(dual_timer_pkg::ADDR_CONTROL, 32'h50);
    pulses0 <= 8'h05;
    pulses1 <= 8'h03;
    start0 <= 1'b1;
    start1 <= 1'b1;
    tick(1);
    start0 <= 1'b0;
    start1 <= 1'b0;
    for (int k = 0; k < 400 && (busy0 | busy1) !== 1'b0; k++) tick(1);
    tick(40);
    wr(dual_timer_pkg::ADDR_CONTROL, 32'h0);
    rdchk("pin count0", dual_timer_pkg::ADDR_CNT0, 32'h5);
    rdchk("pin count1", dual_timer_pkg::ADDR_CNT1, 32'h3);
  endtask : t_pins
  task automatic t_freeze;
    wr(dual_timer_pkg::ADDR_MODE, 32'h30);
    wr(dual_timer_pkg::ADDR_CNT1, 32'h1234);
    run_read(8'h40, 240, dual_timer_pkg::ADDR_CNT1);
    chk("frozen count1", 32'h1234, v);
  endtask : t_freeze
  task automatic t_irq;
    wr(dual_timer_pkg::ADDR_IRQ_MASK, 32'h1);
    wr(dual_timer_pkg::ADDR_CONTROL, 32'h20);
    tick(2);
    chk("flag0 and irq", 32'h5, {29'h0, irq, flags});
    rdchk("status view", dual_timer_pkg::ADDR_IRQ_STAT, 32'h1);
    svc <= 2'h1;
    tick(1);
    svc <= 2'h0;
    tick(2);
    chk("after service0", 32'h0, {29'h0, irq, flags});
    wr(dual_timer_pkg::ADDR_CONTROL, 32'h80);
    tick(2);
    chk("masked flag1", 32'h2, {29'h0, irq, flags});
    svc <= 2'h2;
    tick(1);
    svc <= 2'h0;
    tick(2);
    chk("after service1", 32'h0, {29'h0, irq, flags});
    wr(dual_timer_pkg::ADDR_CONTROL, 32'hA0);
    wr(dual_timer_pkg::ADDR_IRQ_STAT, 32'h3);
    tick(2);
    chk("status clear", 32'h0, {29'h0, irq, flags});
    rdchk("reserved read", dual_timer_pkg::ADDR_IRQ_ACK, 32'h0);
  endtask : t_irq

  task automatic finish_test;
    $display("Errors %0d checks %0d", err_count, samples_checked);
    if (err_count == 0 && samples_checked > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask : finish_test

  initial begin
    #500000;
    err_count++;
    finish_test;
  end
  initial begin
    {hsel, hwrite, start0, start1} = 4'h0;
    {haddr, hwdata, htrans, irq_pin, svc} = 70'h0;
    {pulses0, pulses1} = 16'h0000;
    hsize = 3'h2;
    i_reset = 1'b1;
    err_count = 0;
    samples_checked = 0;
    repeat (6) @(posedge i_clock);
    i_reset <= 1'b0;
    tick(1);
    t_reset;
    t_rate;
    t_modes;
    t_gate;
    t_pins;
    t_freeze;
    t_irq;
    finish_test;
  end
endmodule : dual_timer_counter_tb_top
